// ===== rtl/dft_trip_mgr.sv
// fault-trip manager: gathers protection conditions, latches trips and blocks the drive output
// How it works
// - heat-sink temperature above configured limit sets a latched overtemperature trip
// - short-circuit current report sets a latched short-circuit trip
// - terminal input whose selector is code 4 sets a latched outside fault trip
// - terminal input whose selector is code 5 blocks output while asserted
// - memory, converter offset or either watchdog error sets a fatal fault
// - power-switch temperature sensor error sets a latched thermistor open fault
// - fan error sets a latched fan trip when fan select is zero
// - active pre-regulation with feedback continuously below set value latches feedback-loss trip
// - brake control selected and starting current below release level latches brake fault
// - either safety input low latches its own safety path fault
// - nonzero loss action: non-keypad command error while running gives level trip
// - missing or badly connected I/O board or card shows link hold
// - link hold longer than five seconds latches timeout trip with rotating display
// - keypad communication failure during parameter write latches a setting write trip
// - installed card with communication error latches a card link trip
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "dft_cfg.svh"
module dft_trip_mgr #(
	parameter int HOLD_CYC = `DFT_HOLD_S * `DFT_CLK_HZ,
	parameter int FB_CYC   = `DFT_FB_MS * (`DFT_CLK_HZ / 1000),
	parameter int BRK_CYC  = `DFT_BRK_MS * (`DFT_CLK_HZ / 1000),
	parameter int ROT_CYC  = `DFT_ROT_MS * (`DFT_CLK_HZ / 1000)
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire dft_pkg::dft_wb_req_t wb_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o,
	// protection conditions
	input  wire dft_pkg::dft_sense_t sense_i,
	input  wire logic [4:0]         term_in_i,
	// power stage, display and interrupt
	output logic                    out_block_o,
	output logic [11:0]             trip_o,
	output logic                    hw_fatal_o,
	output logic                    io_link_hold_o,
	output logic                    cmd_loss_o,
	output logic                    output_block_o,
	output dft_pkg::dft_disp_t      disp_o,
	output logic                    irq_o
);
	import dft_pkg::*;

	logic [`DFT_NEV-1:0]             status_r;
	logic [`DFT_NEV-1:0]             status_nxt;
	logic [`DFT_NEV-1:0]             mask_r;
	logic [`DFT_MIF_N*`DFT_MIF_W-1:0] mif_r;
	logic [11:0]                     opt_r;
	logic [11:0]                     temp_lim_r;
	logic [11:0]                     fb_set_r;
	logic [11:0]                     brk_cur_r;
	logic [`DFT_NTRIP-1:0]           latch_r;
	logic [`DFT_NTRIP-1:0]           latch_nxt;
	logic [`DFT_NTRIP-1:0]           cause;
	logic                            fatal_r;
	logic                            blk_lvl;
	logic                            cmd_lvl;
	logic                            hold_lvl;
	logic                            fatal_c;
	logic [2:0]                      tmr_cond;
	logic [2:0]                      tmr_done;
	logic [31:0]                     tmr_cnt_r [3];
	logic [31:0]                     rot_cnt_r;
	logic                            acc;
	logic                            wr;
	logic                            trip_rst;
	logic [31:0]                     rd_dat;
	logic [`DFT_NEV-1:0]             ev;

	function automatic logic [`DFT_MIF_N-1:0] mif_hit(input logic [`DFT_MIF_N*`DFT_MIF_W-1:0] sel,
		input logic [`DFT_MIF_W-1:0] code);
		logic [`DFT_MIF_N-1:0] h;
		h = '0;
		for (int k = 0; k < `DFT_MIF_N; k++) begin
			h[k] = (sel[k*`DFT_MIF_W +: `DFT_MIF_W] == code);
		end
		return h;
	endfunction

	// bus access
	assign acc      = wb_i.cyc && wb_i.stb && !wb_ack_o;
	assign wr       = acc && wb_i.we && (wb_i.sel == 4'hF);
	assign trip_rst = wr && (wb_i.adr == `DFT_A_CTRL) && wb_i.dat[`DFT_CTRL_RST];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= acc;
			wb_dat_o <= acc ? rd_dat : 32'h0000_0000;
		end
	end

	always_comb begin
		rd_dat = 32'h0000_0000;
		if (wb_i.adr == `DFT_A_STATUS) begin
			rd_dat[`DFT_NEV-1:0] = status_r;
		end else if (wb_i.adr == `DFT_A_MASK) begin
			rd_dat[`DFT_NEV-1:0] = mask_r;
		end else if (wb_i.adr == `DFT_A_MIF) begin
			rd_dat[`DFT_MIF_N*`DFT_MIF_W-1:0] = mif_r;
		end else if (wb_i.adr == `DFT_A_OPT) begin
			rd_dat[11:0] = opt_r;
		end else if (wb_i.adr == `DFT_A_TEMP) begin
			rd_dat[11:0] = temp_lim_r;
		end else if (wb_i.adr == `DFT_A_FBSET) begin
			rd_dat[11:0] = fb_set_r;
		end else if (wb_i.adr == `DFT_A_BRK) begin
			rd_dat[11:0] = brk_cur_r;
		end else if (wb_i.adr == `DFT_A_TRIP) begin
			rd_dat[`DFT_NTRIP-1:0] = latch_r;
		end else if (wb_i.adr == `DFT_A_LIVE) begin
			rd_dat[3:0] = {fatal_r, hold_lvl, cmd_lvl, blk_lvl};
		end
	end

	// configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mask_r     <= '0;
			mif_r      <= '0;
			opt_r      <= `DFT_OPT_RST;
			temp_lim_r <= `DFT_LIM_RST;
			fb_set_r   <= `DFT_LIM_ZERO;
			brk_cur_r  <= `DFT_LIM_ZERO;
		end else if (wr) begin
			if (wb_i.adr == `DFT_A_MASK) begin
				mask_r <= wb_i.dat[`DFT_NEV-1:0];
			end else if (wb_i.adr == `DFT_A_MIF) begin
				mif_r <= wb_i.dat[`DFT_MIF_N*`DFT_MIF_W-1:0];
			end else if (wb_i.adr == `DFT_A_OPT) begin
				opt_r <= wb_i.dat[11:0];
			end else if (wb_i.adr == `DFT_A_TEMP) begin
				temp_lim_r <= wb_i.dat[11:0];
			end else if (wb_i.adr == `DFT_A_FBSET) begin
				fb_set_r <= wb_i.dat[11:0];
			end else if (wb_i.adr == `DFT_A_BRK) begin
				brk_cur_r <= wb_i.dat[11:0];
			end
		end
	end

	// persistence timers: feedback low, brake current low, link hold
	assign tmr_cond[0] = opt_r[`DFT_OPT_PFB] && sense_i.pid_active && (sense_i.feedback < fb_set_r);
	assign tmr_cond[1] = (opt_r[`DFT_OPT_AUX] == `DFT_CODE_BRK) && sense_i.brake_start
		&& (sense_i.out_current < brk_cur_r);
	assign tmr_cond[2] = hold_lvl;

	generate
		for (genvar g = 0; g < 3; g++) begin : g_tmr
			localparam logic [31:0] LIM = (g == 0) ? FB_CYC : (g == 1) ? BRK_CYC : HOLD_CYC;
			always_ff @(posedge clk_i) begin
				if (rst_i || !tmr_cond[g]) begin
					tmr_cnt_r[g] <= 32'h0000_0000;
				end else if (tmr_cnt_r[g] != LIM) begin
					tmr_cnt_r[g] <= tmr_cnt_r[g] + 32'h0000_0001;
				end
			end
			assign tmr_done[g] = tmr_cond[g] && (tmr_cnt_r[g] == LIM);
		end
	endgenerate

	// causes of latched trips
	always_comb begin
		cause     = '0;
		cause[0]  = sense_i.heatsink_temp > temp_lim_r;
		cause[1]  = sense_i.short_circuit;
		cause[2]  = |(term_in_i & mif_hit(mif_r, `DFT_CODE_EXT));
		cause[3]  = sense_i.ntc_err;
		cause[4]  = sense_i.fan_err && !opt_r[`DFT_OPT_FAN];
		cause[5]  = tmr_done[0];
		cause[6]  = tmr_done[1];
		cause[7]  = !sense_i.safety_a;
		cause[8]  = !sense_i.safety_b;
		cause[9]  = tmr_done[2];
		cause[10] = sense_i.keypad_comm_err && sense_i.param_write;
		cause[11] = opt_r[`DFT_OPT_CARD] && sense_i.card_comm_err;
	end

	assign blk_lvl  = |(term_in_i & mif_hit(mif_r, `DFT_CODE_BLK));
	assign cmd_lvl  = (opt_r[`DFT_OPT_CLA] != 3'h0) && sense_i.running && !sense_i.cmd_from_keypad
		&& sense_i.cmd_err;
	assign hold_lvl = !sense_i.io_board_ok || (opt_r[`DFT_OPT_CARD] && !sense_i.comm_card_ok);
	assign fatal_c  = sense_i.nvm_access_error || sense_i.adc_offset_err || sense_i.wdog1_err
		|| sense_i.wdog2_err;

	// a cause still present at reset keeps its trip
	assign latch_nxt = (trip_rst ? '0 : latch_r) | cause;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			latch_r <= '0;
			fatal_r <= 1'b0;
		end else begin
			latch_r <= latch_nxt;
			fatal_r <= fatal_r || fatal_c;
		end
	end

	// outputs to power stage and display
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			out_block_o    <= 1'b0;
			trip_o         <= '0;
			hw_fatal_o     <= 1'b0;
			io_link_hold_o <= 1'b0;
			cmd_loss_o     <= 1'b0;
			output_block_o <= 1'b0;
		end else begin
			out_block_o    <= (|latch_nxt) || fatal_r || fatal_c || blk_lvl || cmd_lvl;
			trip_o         <= latch_nxt;
			hw_fatal_o     <= fatal_r || fatal_c;
			io_link_hold_o <= hold_lvl;
			cmd_loss_o     <= cmd_lvl;
			output_block_o <= blk_lvl;
		end
	end

	// rotating display pattern while the hold timeout trip stands
	always_ff @(posedge clk_i) begin
		if (rst_i || !latch_r[9]) begin
			rot_cnt_r <= 32'h0000_0000;
			disp_o    <= DSP_FULL;
		end else if (rot_cnt_r == ROT_CYC - 1) begin
			rot_cnt_r <= 32'h0000_0000;
			disp_o    <= (disp_o == DSP_BLANK) ? DSP_FULL : dft_disp_t'(disp_o + 3'h1);
		end else begin
			rot_cnt_r <= rot_cnt_r + 32'h0000_0001;
		end
	end

	// interrupt status: sticky, write one to clear, new event wins over clear
	always_comb begin
		ev                   = '0;
		ev[`DFT_NTRIP-1:0]   = latch_nxt & ~latch_r;
		ev[`DFT_EV_FATAL]    = fatal_c && !hw_fatal_o;
		ev[`DFT_EV_CMD]      = cmd_lvl && !cmd_loss_o;
		ev[`DFT_EV_BLK]      = blk_lvl && !output_block_o;
		ev[`DFT_EV_HOLD]     = hold_lvl && !io_link_hold_o;
		status_nxt = status_r;
		if (wr && (wb_i.adr == `DFT_A_STATUS)) begin
			status_nxt = status_r & ~wb_i.dat[`DFT_NEV-1:0];
		end
		status_nxt = status_nxt | ev;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= '0;
			irq_o    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_o    <= |(status_nxt & mask_r);
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_hold_long;
		hold_lvl [*8];
	endsequence

	// bus request taken, then a single ack pulse
	sequence s_wb_take;
		wb_i.cyc && wb_i.stb && !wb_ack_o;
	endsequence
	sequence s_wb_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	heat_trip_a: assert property (sense_i.heatsink_temp > temp_lim_r |=> trip_o[0] && out_block_o)
		else $error("overtemperature did not trip");
	short_trip_a: assert property ($rose(sense_i.short_circuit) |=> trip_o[1])
		else $error("short circuit did not trip");
	ext_trip_a: assert property (|(term_in_i & mif_hit(mif_r, `DFT_CODE_EXT)) |=> trip_o[2])
		else $error("external trip missing");
	block_level_a: assert property (blk_lvl ##1 !blk_lvl |=> !output_block_o)
		else $error("output block did not follow input");
	fatal_hold_a: assert property (hw_fatal_o |=> hw_fatal_o && out_block_o)
		else $error("fatal fault released");
	fan_sel_a: assert property (opt_r[`DFT_OPT_FAN] && $stable(opt_r) && !$past(sense_i.fan_err)
		&& !trip_o[4] |=> !trip_o[4])
		else $error("fan trip with fan select set");
	safety_trip_a: assert property (!sense_i.safety_a || !sense_i.safety_b
		|=> trip_o[7] || trip_o[8])
		else $error("safety fault not latched");
	cmd_loss_a: assert property (opt_r[`DFT_OPT_CLA] == 3'h0 |=> !cmd_loss_o)
		else $error("command loss with action off");
	hold_flag_a: assert property (s_hold_long |-> io_link_hold_o)
		else $error("hold indication missing");
	latch_keep_a: assert property (trip_o[3] && !trip_rst |=> trip_o[3])
		else $error("latched trip dropped without reset");
	card_trip_a: assert property (opt_r[`DFT_OPT_CARD] && sense_i.card_comm_err |=> trip_o[11])
		else $error("card link trip missing");
	irq_gate_a: assert property (mask_r == '0 |=> !irq_o)
		else $error("interrupt with all masked");
	irq_set_a: assert property (|(status_nxt & mask_r) |=> irq_o)
		else $error("interrupt missing for unmasked status");
	ev_wins_a: assert property (ev != '0 |=> (status_r & $past(ev)) == $past(ev))
		else $error("status event lost against clear");
	wb_answer_a: assert property (s_wb_take |=> s_wb_pulse)
		else $error("bus ack not a single pulse after request");

	// single-cycle latched causes
	ntc_trip_a: assert property (sense_i.ntc_err |=> trip_o[3])
		else $error("thermistor open trip missing");
	fan_trip_a: assert property (sense_i.fan_err && !opt_r[`DFT_OPT_FAN] |=> trip_o[4])
		else $error("fan trip missing");
	safe_b_trip_a: assert property (!sense_i.safety_b |=> trip_o[8])
		else $error("safety path b fault missing");
	param_trip_a: assert property (sense_i.keypad_comm_err && sense_i.param_write |=> trip_o[10])
		else $error("setting write trip missing");
	card_off_a: assert property (!opt_r[`DFT_OPT_CARD] && !trip_o[11] |=> !trip_o[11])
		else $error("card link trip without card");
	temp_quiet_a: assert property (sense_i.heatsink_temp <= temp_lim_r && !trip_o[0] |=> !trip_o[0])
		else $error("overtemperature trip below limit");
	latch_clear_a: assert property (trip_rst && cause == '0 |=> trip_o == '0)
		else $error("trip reset did not clear");

	// level and fatal conditions
	blk_follow_a: assert property (blk_lvl |=> output_block_o && out_block_o)
		else $error("output block not raised");
	fatal_set_a: assert property (fatal_c |=> hw_fatal_o && out_block_o)
		else $error("fatal fault not raised");
	cmd_follow_a: assert property (cmd_lvl |=> cmd_loss_o && out_block_o)
		else $error("command loss not raised");
	cmd_keypad_a: assert property (sense_i.cmd_from_keypad |=> !cmd_loss_o)
		else $error("command loss from keypad source");
	hold_set_a: assert property (hold_lvl |=> io_link_hold_o)
		else $error("hold indication late");
	hold_clear_a: assert property (!hold_lvl |=> !io_link_hold_o)
		else $error("hold indication stuck");

	// persistence timers
	fb_trip_a: assert property (tmr_cond[0] && tmr_cnt_r[0] == FB_CYC |=> trip_o[5])
		else $error("feedback loss trip missing");
	fb_restart_a: assert property (!tmr_cond[0] |=> tmr_cnt_r[0] == 32'h0000_0000)
		else $error("feedback timer not restarted");
	brk_trip_a: assert property (tmr_cond[1] && tmr_cnt_r[1] == BRK_CYC |=> trip_o[6])
		else $error("brake current trip missing");
	brk_restart_a: assert property (!tmr_cond[1] |=> tmr_cnt_r[1] == 32'h0000_0000)
		else $error("brake timer not restarted");
	hold_trip_a: assert property (hold_lvl && tmr_cnt_r[2] == HOLD_CYC |=> trip_o[9])
		else $error("hold timeout trip missing");
	hold_restart_a: assert property (!hold_lvl |=> tmr_cnt_r[2] == 32'h0000_0000)
		else $error("hold timer not restarted");
	disp_idle_a: assert property (!trip_o[9] |=> disp_o == DSP_FULL)
		else $error("display rotating without timeout trip");
endmodule

// ===== common/dft_cfg.svh
// register map, field positions, codes and timing constants of the fault-trip manager
`ifndef DFT_CFG_SVH
`define DFT_CFG_SVH
`define DFT_A_STATUS   8'h00
`define DFT_A_MASK     8'h04
`define DFT_A_CTRL     8'h08
`define DFT_A_MIF      8'h0C
`define DFT_A_OPT      8'h10
`define DFT_A_TEMP     8'h14
`define DFT_A_FBSET    8'h18
`define DFT_A_BRK      8'h1C
`define DFT_A_TRIP     8'h20
`define DFT_A_LIVE     8'h24
`define DFT_MIF_W      6
`define DFT_MIF_N      5
`define DFT_CODE_EXT   6'h04
`define DFT_CODE_BLK   6'h05
`define DFT_CODE_BRK   6'h23
`define DFT_OPT_FAN    0
`define DFT_OPT_CLA    3:1
`define DFT_OPT_AUX    9:4
`define DFT_OPT_PFB    10
`define DFT_OPT_CARD   11
`define DFT_OPT_RST    12'h000
`define DFT_LIM_RST    12'hFFF
`define DFT_LIM_ZERO   12'h000
`define DFT_CTRL_RST   0
`define DFT_NTRIP      12
`define DFT_NEV        16
`define DFT_EV_FATAL   12
`define DFT_EV_CMD     13
`define DFT_EV_BLK     14
`define DFT_EV_HOLD    15
`define DFT_CLK_HZ     40000000
`define DFT_HOLD_S     5
`define DFT_FB_MS      1000
`define DFT_BRK_MS     100
`define DFT_ROT_MS     500
`endif

// ===== common/dft_pkg.sv
// types shared by the fault-trip manager and its users
package dft_pkg;
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [7:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} dft_wb_req_t;
	typedef struct packed {
		logic [11:0] heatsink_temp;
		logic        short_circuit;
		logic        nvm_access_error;
		logic        adc_offset_err;
		logic        wdog1_err;
		logic        wdog2_err;
		logic        ntc_err;
		logic        fan_err;
		logic        pid_active;
		logic [11:0] feedback;
		logic [11:0] out_current;
		logic        brake_start;
		logic        safety_a;
		logic        safety_b;
		logic        running;
		logic        cmd_err;
		logic        cmd_from_keypad;
		logic        io_board_ok;
		logic        comm_card_ok;
		logic        keypad_comm_err;
		logic        param_write;
		logic        card_comm_err;
	} dft_sense_t;
	typedef enum logic [2:0] {DSP_FULL, DSP_GAP1, DSP_GAP2, DSP_GAP3, DSP_SHORT1, DSP_SHORT2, DSP_BLANK} dft_disp_t;
endpackage

// ===== verification/dft_plant.sv
// far-side model: healthy sensors and cards; the bench injects faults into it
`timescale 1ns/1ps
module dft_plant (
	// sensor bundle toward the trip manager
	output dft_pkg::dft_sense_t sense_o
);
	import dft_pkg::*;
	dft_sense_t s;
	// safety inputs and board presence are active low problems, so healthy means high
	function automatic dft_sense_t good();
		return '{heatsink_temp: 12'h100, feedback: 12'h800, out_current: 12'h800, safety_a: 1'b1,
			safety_b: 1'b1, io_board_ok: 1'b1, comm_card_ok: 1'b1, default: '0};
	endfunction
	task automatic heal();
		s <= good();
	endtask
	initial begin
		s = good();
	end
	assign sense_o = s;
endmodule

// ===== verification/testbench.sv
// self-checking bench of the fault-trip manager
`timescale 1ns/1ps
`include "dft_cfg.svh"
module testbench;
	import dft_pkg::*;
	localparam int HOLD = 20;
	localparam int FB   = 10;
	localparam int BRK  = 10;
	localparam logic [11:0] EXP [6] = '{12'h008, 12'h010, 12'h080, 12'h100, 12'h400, 12'h800};
	logic        clk_i;
	logic        rst_i;
	dft_wb_req_t wb_r;
	logic [4:0]  term_r;
	logic [31:0] wb_dat_o;
	logic [31:0] q;
	logic        wb_ack_o;
	logic        out_block_o;
	logic        hw_fatal_o;
	logic        hold_o;
	logic        cmd_loss_o;
	logic        blk_o;
	logic        irq_o;
	logic        seen;
	logic [11:0] trip_o;
	dft_disp_t   disp_o;
	dft_sense_t  sense;
	int          fails;
	int          n_compared;
	dft_plant dft_plant_i (.sense_o(sense));
	dft_trip_mgr #(.HOLD_CYC(HOLD), .FB_CYC(FB), .BRK_CYC(BRK), .ROT_CYC(4)) dft_trip_mgr_i (
		.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_r), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sense_i(sense), .term_in_i(term_r), .out_block_o(out_block_o), .trip_o(trip_o),
		.hw_fatal_o(hw_fatal_o), .io_link_hold_o(hold_o), .cmd_loss_o(cmd_loss_o),
		.output_block_o(blk_o), .disp_o(disp_o), .irq_o(irq_o));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// every task starts and ends just after a rising edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_r <= '{1'b1, 1'b1, w, a, 4'hF, d};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_r <= '0;
		@(posedge clk_i);
	endtask
	task automatic clr();
		dft_plant_i.heal();
		term_r <= '0;
		wb(1'b1, `DFT_A_CTRL, 32'h1);
		wb(1'b1, `DFT_A_STATUS, 32'hFFFF);
		ticks(2);
	endtask
	task automatic do_reset();
		dft_plant_i.heal();
		rst_i <= 1'b1;
		ticks(8);
		rst_i <= 1'b0;
		ticks(1);
	endtask
	task automatic t_reset();
		cmp("trip", 12'h000, trip_o);
		cmp("disp", DSP_FULL, disp_o);
		wb(1'b0, `DFT_A_TEMP, 32'h0);
		cmp("limit", 32'hFFF, q);
		wb(1'b0, `DFT_A_OPT, 32'h0);
		cmp("opt", 32'h0, q);
		wb(1'b1, 8'h40, 32'h5);
		wb(1'b0, 8'h40, 32'h0);
		cmp("unmapped", 32'h0, q);
	endtask
	task automatic t_short();
		wb(1'b1, `DFT_A_MASK, 32'h2);
		dft_plant_i.s.short_circuit <= 1'b1;
		ticks(2);
		cmp("trip", 12'h002, trip_o);
		cmp("block", 1'b1, out_block_o);
		ticks(1);
		cmp("irq", 1'b1, irq_o);
		dft_plant_i.s.short_circuit <= 1'b0;
		ticks(3);
		cmp("trip", 12'h002, trip_o);
		wb(1'b0, `DFT_A_STATUS, 32'h0);
		cmp("status", 32'h2, q);
		clr();
		cmp("trip", 12'h000, trip_o);
		cmp("irq", 1'b0, irq_o);
	endtask
	task automatic t_temp();
		wb(1'b1, `DFT_A_TEMP, 32'h200);
		dft_plant_i.s.heatsink_temp <= 12'h200;
		ticks(2);
		cmp("trip", 12'h000, trip_o);
		dft_plant_i.s.heatsink_temp <= 12'h201;
		ticks(2);
		cmp("trip", 12'h001, trip_o);
		clr();
	endtask
	task automatic t_term();
		wb(1'b1, `DFT_A_MIF, 32'h0500_4000);
		term_r <= 5'b10001;
		ticks(2);
		cmp("blk", 1'b1, blk_o);
		cmp("block", 1'b1, out_block_o);
		cmp("trip", 12'h000, trip_o);
		term_r <= 5'b00100;
		ticks(2);
		cmp("blk", 1'b0, blk_o);
		cmp("trip", 12'h004, trip_o);
		clr();
	endtask
	task automatic t_fatal();
		for (int k = 0; k < 4; k++) begin
			dft_plant_i.s.nvm_access_error <= (k == 0);
			dft_plant_i.s.adc_offset_err <= (k == 1);
			dft_plant_i.s.wdog1_err <= (k == 2);
			dft_plant_i.s.wdog2_err <= (k == 3);
			ticks(2);
			cmp("fatal", 1'b1, hw_fatal_o);
			clr();
			cmp("fatal", 1'b1, hw_fatal_o);
			do_reset();
			cmp("fatal", 1'b0, hw_fatal_o);
		end
	endtask
	task automatic t_latch();
		wb(1'b1, `DFT_A_OPT, 32'h1);
		dft_plant_i.s.fan_err <= 1'b1;
		ticks(2);
		cmp("trip", 12'h000, trip_o);
		wb(1'b1, `DFT_A_OPT, 32'h800);
		clr();
		for (int k = 0; k < 6; k++) begin
			case (k)
				0: dft_plant_i.s.ntc_err <= 1'b1;
				1: dft_plant_i.s.fan_err <= 1'b1;
				2: dft_plant_i.s.safety_a <= 1'b0;
				3: dft_plant_i.s.safety_b <= 1'b0;
				4: dft_plant_i.s.keypad_comm_err <= 1'b1;
				default: dft_plant_i.s.card_comm_err <= 1'b1;
			endcase
			dft_plant_i.s.param_write <= 1'b1;
			ticks(2);
			cmp("trip", EXP[k], trip_o);
			clr();
		end
	endtask
	task automatic t_cmd();
		wb(1'b1, `DFT_A_OPT, 32'h2);
		dft_plant_i.s.running <= 1'b1;
		dft_plant_i.s.cmd_err <= 1'b1;
		dft_plant_i.s.cmd_from_keypad <= 1'b1;
		ticks(2);
		cmp("loss", 1'b0, cmd_loss_o);
		dft_plant_i.s.cmd_from_keypad <= 1'b0;
		ticks(2);
		cmp("loss", 1'b1, cmd_loss_o);
		cmp("block", 1'b1, out_block_o);
		dft_plant_i.s.cmd_err <= 1'b0;
		ticks(2);
		cmp("loss", 1'b0, cmd_loss_o);
		clr();
	endtask
	task automatic t_hold();
		dft_plant_i.s.io_board_ok <= 1'b0;
		ticks(2);
		cmp("hold", 1'b1, hold_o);
		ticks(HOLD - 3);
		cmp("trip", 12'h000, trip_o);
		ticks(6);
		cmp("trip", 12'h200, trip_o);
		seen = 1'b0;
		for (int k = 0; k < 8; k++) begin
			ticks(1);
			seen = seen | (disp_o != DSP_FULL);
		end
		cmp("rotating", 1'b1, seen);
		dft_plant_i.s.io_board_ok <= 1'b1;
		ticks(2);
		cmp("hold", 1'b0, hold_o);
		cmp("trip", 12'h200, trip_o);
		clr();
		cmp("disp", DSP_FULL, disp_o);
	endtask
	task automatic t_slow();
		wb(1'b1, `DFT_A_FBSET, 32'h400);
		wb(1'b1, `DFT_A_OPT, 32'h400);
		dft_plant_i.s.pid_active <= 1'b1;
		dft_plant_i.s.feedback <= 12'h3FF;
		ticks(FB + 4);
		cmp("trip", 12'h020, trip_o);
		clr();
		wb(1'b1, `DFT_A_BRK, 32'h400);
		wb(1'b1, `DFT_A_OPT, 32'h230);
		dft_plant_i.s.brake_start <= 1'b1;
		dft_plant_i.s.out_current <= 12'h100;
		ticks(BRK + 4);
		cmp("trip", 12'h040, trip_o);
		clr();
	endtask
	task automatic summarize();
		if (fails == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#(25 * 6000);
		fails++;
		summarize();
	end
	initial begin
		rst_i = 1'b1;
		wb_r = '0;
		term_r = '0;
		fails = 0;
		n_compared = 0;
		do_reset();
		t_reset();
		t_short();
		t_temp();
		t_term();
		t_fatal();
		t_latch();
		t_cmd();
		t_hold();
		t_slow();
		summarize();
	end
endmodule
